// *** src/rxfbp_pkg.sv ***
// Constants and types for the receive fabric bus packer
package rxfbp_pkg;
   localparam int          BUS_W        = 64;      // Receive bus width
   localparam int          HALF_W       = 32;      // Bus half carrying one byte
   localparam int          HI_OFS       = 32;      // Start of high byte half
   localparam int          DATA_LSB     = 0;       // Data byte position
   localparam int          CTRL_POS     = 8;       // Control char flag
   localparam int          ALEN_POS     = 8;       // Alignment length flag
   localparam int          CERR_POS     = 9;       // Code error flag
   localparam int          SYNC_POS     = 10;      // Sync flag
   localparam int          DERR_POS     = 11;      // Disparity error flag
   localparam int          PDET_POS     = 12;      // Pattern detect flag
   localparam int          PIPE_LSB     = 13;      // PIPE status field
   localparam int          FIFO_DEPTH   = 8;       // Input buffer words
   localparam logic [11:0] CTRL_OFS     = 12'h000; // Control register
   localparam logic [11:0] STAT_OFS     = 12'h004; // Status register
   localparam int          MODE_BIT     = 0;       // Control: SONET mode
   localparam int          PIPE_BIT     = 1;       // Control: PIPE status on
   localparam logic [1:0]  CTRL_RST     = 2'h0;    // Control reset value
   localparam int          LVL_LSB      = 0;       // Status: buffer level
   localparam int          OVLD_BIT     = 8;       // Status: bus holds word
   // Word encoding mode
   typedef enum logic {MODE_8B10B, MODE_SONET} rxfbp_mode_t;
   // One received byte with its flags
   typedef struct packed {
      logic [7:0] data;
      logic       ctrl;
      logic       codeErr;
      logic       sync;
      logic       dispErr;
      logic       patDet;
      logic       align_pattern_length_flag;
      logic [1:0] pipeStatus;
   } rxfbp_byte_t;
   // Two bytes received in one cycle
   typedef struct packed {
      rxfbp_byte_t hi;
      rxfbp_byte_t lo;
   } rxfbp_word_t;
endpackage : rxfbp_pkg

// *** src/rxfbp_top.sv ***
// Input buffer and receive bus packer with APB control
`timescale 1ns/1ps

// Synchronous FIFO with registered flags
module rxfbp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [7:0]            level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   // Refuse depths the pointer logic cannot serve
   if (DEPTH < 2 || DEPTH > 255 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("rxfbp_fifo: DEPTH must be a power of two from 2 to 128");
   end

   logic [WIDTH-1:0] mem [DEPTH];   // Storage
   logic [AW-1:0]    wrPtr_ff;      // Write pointer
   logic [AW-1:0]    rdPtr_ff;      // Read pointer
   logic [CW-1:0]    cnt_ff;        // Words held
   logic             notFull_ff;    // Room for a word
   logic             notEmpty_ff;   // A word is held
   logic [AW-1:0]    nxt_wrPtr;
   logic [AW-1:0]    nxt_rdPtr;
   logic [CW-1:0]    nxt_cnt;
   logic             push;
   logic             pop;

   // Next pointers and count
   always_comb begin
      push      = inValid & notFull_ff;
      pop       = outReady & notEmpty_ff;
      nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
      nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
      nxt_cnt   = CW'(cnt_ff + CW'(push) - CW'(pop));
   end

   // Register pointers and flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_ff    <= '0;
         rdPtr_ff    <= '0;
         cnt_ff      <= '0;
         notFull_ff  <= 1'b1;
         notEmpty_ff <= 1'b0;
      end else begin
         wrPtr_ff    <= nxt_wrPtr;
         rdPtr_ff    <= nxt_rdPtr;
         cnt_ff      <= nxt_cnt;
         notFull_ff  <= (nxt_cnt != CW'(DEPTH));
         notEmpty_ff <= (nxt_cnt != '0);
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   assign inReady  = notFull_ff;
   assign outValid = notEmpty_ff;
   assign outData  = mem[rdPtr_ff];
   assign level    = 8'(cnt_ff);
endmodule : rxfbp_fifo

// Top: buffers received byte pairs and packs them onto the bus
module rxfbp_top #(
   parameter int DEPTH = rxfbp_pkg::FIFO_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire rxfbp_pkg::rxfbp_word_t rxWord,
   input  wire logic                   rxValid,
   output logic                        rxReady,
   output logic [rxfbp_pkg::BUS_W-1:0] rxBus,
   output logic                        rxBusValid,
   input  wire logic                   rxBusReady
);
   logic [1:0]                  rstSync_ff;   // Reset release chain
   logic                        rstnS;        // Synchronised reset
   logic                        fifoReady;    // Buffer has room
   rxfbp_pkg::rxfbp_word_t      head;         // Oldest buffered word
   logic [31:0]                 headBits;     // Head as raw bits
   logic                        headValid;    // Head present
   logic [7:0]                  level;        // Buffer fill
   logic                        load;         // Move head onto bus
   logic [1:0]                  ctrl_ff;      // Mode and PIPE enable
   logic [1:0]                  nxt_ctrl;
   logic [rxfbp_pkg::BUS_W-1:0] bus_ff;       // Output bus word
   logic [rxfbp_pkg::BUS_W-1:0] nxt_bus;
   logic                        busValid_ff;  // Output word pending
   logic                        nxt_busValid;
   logic                        inRdy_ff;     // Registered room flag
   logic [31:0]                 prdata_ff;    // Read data
   logic [31:0]                 nxt_prdata;
   logic                        pready_ff;    // Access answer
   logic                        nxt_pready;
   logic                        pslverr_ff;   // Unmapped answer
   logic                        nxt_pslverr;
   rxfbp_pkg::rxfbp_mode_t      mode;         // Current mode
   logic                        pipeOn;       // PIPE status enabled

   // Release reset through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync_ff <= 2'h0;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstnS = rstSync_ff[1];

   // Input buffer; its ready stalls the receive source
   rxfbp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
      .clk      (clk),
      .rstn     (rstnS),
      .inData   (rxWord),
      .inValid  (rxValid & inRdy_ff),
      .inReady  (fifoReady),
      .outData  (headBits),
      .outValid (headValid),
      .outReady (load),
      .level    (level)
   );
   assign head   = rxfbp_pkg::rxfbp_word_t'(headBits);
   assign mode   = rxfbp_pkg::rxfbp_mode_t'(ctrl_ff[rxfbp_pkg::MODE_BIT]);
   assign pipeOn = ctrl_ff[rxfbp_pkg::PIPE_BIT];

   // Pack one byte with its flags into one bus half
   function automatic logic [31:0] pack_half(input rxfbp_pkg::rxfbp_byte_t b,
                                             input rxfbp_pkg::rxfbp_mode_t m,
                                             input logic pipe);
      logic [31:0] r;
      r = '0;
      r[rxfbp_pkg::DATA_LSB +: 8] = b.data;
      r[rxfbp_pkg::SYNC_POS]      = b.sync;
      r[rxfbp_pkg::PDET_POS]      = b.patDet;
      if (m == rxfbp_pkg::MODE_8B10B) begin
         r[rxfbp_pkg::CTRL_POS] = b.ctrl;
         r[rxfbp_pkg::CERR_POS] = b.codeErr;
         r[rxfbp_pkg::DERR_POS] = b.dispErr;
         if (pipe) begin
            r[rxfbp_pkg::PIPE_LSB +: 2] = b.pipeStatus;
         end
      end else begin
         r[rxfbp_pkg::ALEN_POS] = b.align_pattern_length_flag;
      end
      return r;
   endfunction : pack_half

   // Next bus word: load when the bus is free or being taken
   always_comb begin
      load         = headValid & (~busValid_ff | rxBusReady);
      nxt_bus      = bus_ff;
      nxt_busValid = busValid_ff & ~rxBusReady;
      if (load) begin
         nxt_bus      = {pack_half(head.hi, mode, pipeOn),
                         pack_half(head.lo, mode, pipeOn)};
         nxt_busValid = 1'b1;
      end
   end

   // Register bus word and room flag
   always_ff @(posedge clk or negedge rstnS) begin
      if (!rstnS) begin
         bus_ff      <= '0;
         busValid_ff <= 1'b0;
         inRdy_ff    <= 1'b0;
      end else begin
         bus_ff      <= nxt_bus;
         busValid_ff <= nxt_busValid;
         inRdy_ff    <= fifoReady & ~(rxValid & inRdy_ff & (level == 8'(DEPTH - 1)) & ~load);
      end
   end

   // APB slave: one wait state, write lands on the pready edge
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_prdata  = prdata_ff;
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
      if (psel & penable & ~pready_ff) begin
         // Answer the access on the next cycle
         nxt_pready = 1'b1;
         unique case (paddr)
            rxfbp_pkg::CTRL_OFS: nxt_prdata = {30'h0, ctrl_ff};
            rxfbp_pkg::STAT_OFS: nxt_prdata = {23'h0, busValid_ff, level};
            default: begin
               nxt_prdata  = 32'h0;
               nxt_pslverr = 1'b1;
            end
         endcase
      end
      if (psel & penable & pready_ff & pwrite & (paddr == rxfbp_pkg::CTRL_OFS)) begin
         nxt_ctrl = pwdata[1:0];
      end
   end

   // Register APB state
   always_ff @(posedge clk or negedge rstnS) begin
      if (!rstnS) begin
         ctrl_ff    <= rxfbp_pkg::CTRL_RST;
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign rxReady    = inRdy_ff;
   assign rxBus      = bus_ff;
   assign rxBusValid = busValid_ff;

   // Checks on the packed bus
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstnS);

   sequence s_load;
      load;
   endsequence
   sequence s_8b;
      load && mode == rxfbp_pkg::MODE_8B10B;
   endsequence
   sequence s_sonet;
      load && mode == rxfbp_pkg::MODE_SONET;
   endsequence

   a_bus_hold: assert property (rxBusValid && !rxBusReady |=> $stable(rxBus) && rxBusValid)
      else $error("bus word changed before taken");
   a_data_bytes: assert property (s_load |=> rxBus[7:0] == $past(head.lo.data)
                                  && rxBus[39:32] == $past(head.hi.data))
      else $error("data bytes misplaced");
   a_ctrl_flags: assert property (s_8b |=> rxBus[8] == $past(head.lo.ctrl) && rxBus[40] == $past(head.hi.ctrl))
      else $error("control flags misplaced");
   a_code_err: assert property (s_8b |=> rxBus[9] == $past(head.lo.codeErr)
                                && rxBus[41] == $past(head.hi.codeErr))
      else $error("code error flags misplaced");
   a_sync_flags: assert property (s_load |=> rxBus[10] == $past(head.lo.sync) && rxBus[42] == $past(head.hi.sync))
      else $error("sync flags misplaced");
   a_disp_err: assert property (s_8b |=> rxBus[11] == $past(head.lo.dispErr)
                                && rxBus[43] == $past(head.hi.dispErr))
      else $error("disparity flags misplaced");
   a_pat_detect: assert property (s_load |=> rxBus[12] == $past(head.lo.patDet)
                                  && rxBus[44] == $past(head.hi.patDet))
      else $error("pattern flags misplaced");
   a_pipe_status: assert property (s_8b ##0 pipeOn |=> rxBus[14:13] == $past(head.lo.pipeStatus)
                                   && rxBus[46:45] == $past(head.hi.pipeStatus))
      else $error("PIPE status misplaced");
   a_sonet_data: assert property (s_sonet |=> rxBus[7:0] == $past(head.lo.data)
                                  && rxBus[39:32] == $past(head.hi.data))
      else $error("SONET data misplaced");
   a_align_len: assert property (s_sonet |=> rxBus[8] == $past(head.lo.align_pattern_length_flag)
                                 && rxBus[40] == $past(head.hi.align_pattern_length_flag))
      else $error("alignment length misplaced");
   a_unused_zero: assert property (s_load |=> rxBus[63:47] == '0 && rxBus[31:15] == '0
                                   && ($past(mode) == rxfbp_pkg::MODE_8B10B || (rxBus[14:13] == '0
                                   && rxBus[11] == 1'b0 && rxBus[9] == 1'b0)))
      else $error("unused bus bits not zero");
endmodule : rxfbp_top

// *** testbench/rxfbp_sink.sv ***
// Fabric-side consumer model that collects packed bus words
`timescale 1ns/1ps
module rxfbp_sink (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [63:0] rxBus,
   input  wire logic        rxBusValid,
   input  wire logic        stall,
   output logic             rxBusReady
);
   logic [63:0] got[$]; // Words taken from the bus, in order
   // Ready follows the stall request one edge later; a word counts at a valid-and-ready edge
   always @(posedge clk) begin
      rxBusReady <= rstn && !stall;
      if (rxBusValid === 1'b1 && rxBusReady === 1'b1) begin
         got.push_back(rxBus);
      end
   end
endmodule : rxfbp_sink

// *** testbench/tb_rxfbp_top.sv ***
// Self-checking bench for the receive bus packer
`timescale 1ns/1ps
module tb_rxfbp_top;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, rxValid = 0, stall = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, rxReady, rxBusValid, rxBusReady, son = 0, pipe = 0;
   logic [63:0] rxBus, exp[$];
   rxfbp_pkg::rxfbp_word_t rxWord = '0;
   int mismatches = 0, numChecks = 0;
   rxfbp_top #(.DEPTH(8)) uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxWord(rxWord),
      .rxValid(rxValid), .rxReady(rxReady), .rxBus(rxBus), .rxBusValid(rxBusValid), .rxBusReady(rxBusReady));
   rxfbp_sink sink (.clk(clk), .rstn(rstn), .rxBus(rxBus), .rxBusValid(rxBusValid), .stall(stall),
      .rxBusReady(rxBusReady));
   // 50 MHz clock
   always #10 clk = ~clk;
   // Verdict and end of run
   task finish_test;
      if (mismatches == 0 && numChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // Compare and count
   task check(input string what, input logic [63:0] seen, input logic [63:0] want);
      numChecks++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask : check
   // One APB transfer; waits for pready under a bound
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (i == 20) begin mismatches++; finish_test(); end
      // Idle cycle so a following setup never reassigns psel in this time step
      @(posedge clk);
   endtask : apb
   // Expected bus image of one word, built bit by bit
   function automatic logic [63:0] expPack(rxfbp_pkg::rxfbp_word_t w);
      logic [63:0] e;
      e = 64'h0;
      e[7:0] = w.lo.data; e[39:32] = w.hi.data;
      e[10] = w.lo.sync; e[42] = w.hi.sync;
      e[12] = w.lo.patDet; e[44] = w.hi.patDet;
      if (son) begin
         e[8] = w.lo.align_pattern_length_flag; e[40] = w.hi.align_pattern_length_flag;
      end else begin
         e[8] = w.lo.ctrl; e[40] = w.hi.ctrl;
         e[9] = w.lo.codeErr; e[41] = w.hi.codeErr;
         e[11] = w.lo.dispErr; e[43] = w.hi.dispErr;
         if (pipe) begin
            e[14:13] = w.lo.pipeStatus; e[46:45] = w.hi.pipeStatus;
         end
      end
      return e;
   endfunction : expPack
   // Offer one word; valid stays up so words go back to back
   task pushWord(input logic [31:0] w, input int lim, output bit ok);
      ok = 0;
      rxWord <= rxfbp_pkg::rxfbp_word_t'(w); rxValid <= 1'b1;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge clk);
         if (rxReady === 1'b1) ok = 1;
      end
      if (ok) exp.push_back(expPack(rxfbp_pkg::rxfbp_word_t'(w)));
   endtask : pushWord
   // Wait until the sink holds every taken word, then compare in order
   task drain;
      int i;
      for (i = 0; i < 300 && sink.got.size() < exp.size(); i++) @(posedge clk);
      check("word count", 64'(sink.got.size()), 64'(exp.size()));
      // A wait that ran out has just counted a mismatch: end the run
      if (sink.got.size() < exp.size()) finish_test();
      for (i = 0; i < exp.size() && i < sink.got.size(); i++) check("rxBus", sink.got[i], exp[i]);
      exp.delete(); sink.got.delete();
   endtask : drain
   // Register reset values, access kinds and an unmapped address
   task testRegs;
      apb(1'b0, rxfbp_pkg::CTRL_OFS, 32'h0); check("ctrl reset", 64'(rd), 64'h0);
      apb(1'b0, rxfbp_pkg::STAT_OFS, 32'h0); check("stat reset", 64'(rd), 64'h0);
      apb(1'b1, rxfbp_pkg::CTRL_OFS, 32'hFFFFFFFF);
      apb(1'b0, rxfbp_pkg::CTRL_OFS, 32'h0); check("ctrl mask", 64'(rd), 64'h3);
      apb(1'b1, rxfbp_pkg::STAT_OFS, 32'hFFFFFFFF); check("stat wr err", 64'(err), 64'h0);
      apb(1'b0, rxfbp_pkg::STAT_OFS, 32'h0); check("stat ro", 64'(rd), 64'h0);
      apb(1'b0, 12'h010, 32'h0); check("unmapped err", 64'(err), 64'h1);
      check("unmapped data", 64'(rd), 64'h0);
   endtask : testRegs
   // Every mode and PIPE setting, back-to-back words including all-ones
   task testModes;
      bit ok;
      for (int m = 0; m < 4; m++) begin
         son = m[0]; pipe = m[1];
         apb(1'b1, rxfbp_pkg::CTRL_OFS, {30'h0, pipe, son});
         for (int k = 0; k < 6; k++) begin
            pushWord(k == 0 ? 32'hFFFFFFFF : 32'h9E3779B9 * (k + m), 50, ok);
            if (!ok) begin mismatches++; finish_test(); end
         end
         rxValid <= 1'b0;
         drain();
      end
   endtask : testModes
   // Stall the sink until the buffer refuses, then drain in order
   task testFill;
      bit ok;
      int n;
      son = 0; pipe = 1;
      apb(1'b1, rxfbp_pkg::CTRL_OFS, 32'h2);
      stall <= 1'b1;
      n = 0; ok = 1;
      while (ok && n < 20) begin
         pushWord(32'h13579BDF + n * 32'h01010101, 4, ok);
         if (ok) n++;
      end
      rxValid <= 1'b0;
      check("refused", 64'(n >= 8 && n <= 9), 64'h1);
      apb(1'b0, rxfbp_pkg::STAT_OFS, 32'h0); check("bus held", 64'(rd[8]), 64'h1);
      stall <= 1'b0;
      drain();
      apb(1'b0, rxfbp_pkg::STAT_OFS, 32'h0); check("empty", 64'(rd), 64'h0);
   endtask : testFill
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      testRegs();
      testModes();
      testFill();
      finish_test();
   end
endmodule : tb_rxfbp_top
